//--- hdl/duhssp_pkg.sv
/*
 package of the dual uart host select and status block: register offsets,
 field positions, reset values and timing counts.
 assumes nothing of its surroundings; imported by duhssp_top.
*/
package duhssp_pkg;
   // register offsets on the three host address lines
   localparam logic [2:0] OFS_DIV_LOW   = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH  = 3'h1;
   localparam logic [2:0] OFS_FIFO_CTL  = 3'h2;
   localparam logic [2:0] OFS_DIV_FRAC  = 3'h3;
   localparam logic [2:0] OFS_FEAT_CTL  = 3'h4;
   localparam logic [2:0] OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] OFS_RX_TRIG   = 3'h6;
   localparam logic [2:0] OFS_TX_TRIG   = 3'h7;

   // field positions
   localparam int FCR_FIFO_EN_BIT   = 0;
   localparam int FCR_BLOCK_BIT     = 3;
   localparam int FEATURE_CONTROL_REG_HALF_DUP_BIT = 3;
   localparam int LSR_DATA_RDY_BIT  = 0;
   localparam int LSR_TX_ROOM_BIT   = 5;
   localparam int LSR_TX_EMPTY_BIT  = 6;
   localparam int DIV_FRAC_BITS     = 4;

   // reset values
   localparam logic [7:0] RST_DIV_LOW  = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH = 8'h00;
   localparam logic [7:0] RST_DIV_FRAC = 8'h00;
   localparam logic [7:0] RST_FIFO_CTL = 8'h00;
   localparam logic [7:0] RST_FEAT_CTL = 8'h00;
   localparam logic [7:0] RST_RX_TRIG  = 8'h08;
   localparam logic [7:0] RST_TX_TRIG  = 8'h08;
   localparam logic [7:0] DIV_ZERO     = 8'h00;

   // timing
   localparam int CLK_PERIOD_NS   = 8;
   localparam int RESET_MIN_NS    = 40;
   localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int NUM_CHAN        = 2;
endpackage : duhssp_pkg

//--- hdl/duhssp_top.sv
/*
 host select and status glue of a dual uart: channel decode in two bus styles,
 per-channel control registers, ready and interrupt pins, id readback.
 assumes host strobes are synchronous to clk; fifo levels, receive time-out
 and shift register state come in from the channel cores.
*/
// How it works
// RULE_01 - reset returns registers and outputs to defaults
// RULE_02 - zero divisors: high reads id, low revision
// RULE_03 - separate selects pick a, b, both, none
// RULE_04 - host never reads with both channels selected
// RULE_05 - single select plus address bit picks channel
// RULE_06 - style pin chooses which decoding applies
// RULE_07 - block bit chooses single-character or block mode
// RULE_08 - no fifo: receive ready low while byte held
// RULE_09 - fifo, no block: receive ready low non-empty
// RULE_10 - block: receive ready falls at trigger, rises empty
// RULE_11 - fifo, no block: transmit ready low when empty
// RULE_12 - block: transmit ready low unless fifo full
// RULE_13 - no fifo: interrupt high when holding register empty
// RULE_14 - half duplex waits for whole transmitter empty
// RULE_15 - fifo: transmit interrupt high below trigger
// RULE_16 - no fifo: receive interrupt high while byte held
// RULE_17 - fifo: receive interrupt high above trigger
// RULE_18 - host access needs no baud oscillator clock
// RULE_19 - line status bits 5, 6 show room, empty
// RULE_20 - half duplex off after reset, bit or pin
// RULE_21 - id reads leave divisor registers untouched
`timescale 1ns/1ps
module duhssp_top #(
   parameter int         FIFO_DEPTH = 64,
   parameter int         CW         = $clog2(FIFO_DEPTH + 1),
   parameter logic [7:0] DEVICE_ID  = 8'h5c,   // arbitrary value
   parameter logic [7:0] REVISION   = 8'h03    // arbitrary value
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 bus_style,
   input  wire logic                 select_chan_a_n,
   input  wire logic                 select_chan_b_n,
   input  wire logic                 channel_address_bit,
   input  wire logic                 read_strobe_n,
   input  wire logic                 write_strobe_n,
   input  wire logic                 read_not_write,
   input  wire logic [2:0]           reg_addr,
   input  wire logic [7:0]           write_data,
   input  wire logic                 half_duplex_enable_n,
   input  wire logic [1:0][CW-1:0]   rx_count,
   input  wire logic [1:0][CW-1:0]   tx_count,
   input  wire logic [1:0]           rx_timeout,
   input  wire logic [1:0]           tx_shift_empty,
   output logic      [7:0]           read_data,
   output logic                      read_data_oe,
   output logic      [1:0]           rx_ready_n,
   output logic      [1:0]           tx_ready_n,
   output logic                      irq_out_chan_a,
   output logic                      irq_out_chan_b,
   output logic      [1:0]           half_duplex_active
);
   import duhssp_pkg::*;

   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);

   // channel decode; the shared pin serves as the single select in that style
   function automatic logic [1:0] chan_sel(input logic style, input logic sa_n,
                                          input logic sb_n, input logic adr);
      logic [1:0] s;
      s = 2'b00;
      if (style) begin
         s = {~sb_n, ~sa_n};                                       // RULE_03
      end else if (!sa_n) begin
         s = adr ? 2'b10 : 2'b01;                                  // RULE_05
      end
      return s;
   endfunction : chan_sel

   logic [1:0] sel;
   logic       acc_on;
   logic       acc_rd;
   logic       acc_prev_r;
   logic       acc_start;

   // the baud oscillator plays no part here, so registers work with it stopped
   always_comb begin                                               // RULE_18
      sel    = chan_sel(bus_style, select_chan_a_n, select_chan_b_n,
                        channel_address_bit);                      // RULE_06
      if (bus_style) begin
         acc_on = (!read_strobe_n || !write_strobe_n) && (sel != 2'b00);
         acc_rd = !read_strobe_n;
      end else begin
         acc_on = sel != 2'b00;
         acc_rd = read_not_write;
      end
   end

   // a write is taken once, on the first cycle of a held strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_prev_r <= 1'b0;
      end else begin
         acc_prev_r <= acc_on;
      end
   end
   assign acc_start = acc_on && !acc_prev_r;

   logic [1:0][7:0] dll_w, dlm_w, dld_w, fcr_w, feature_control_reg_w, lsr_w, rtrg_w, ttrg_w;
   logic [1:0]      irq_w;

   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_ch
         logic [7:0] dll_r, dlm_r, dld_r, fcr_r, feature_control_reg_r, rtrg_r, ttrg_r;
         logic       rx_rdy_n_r, tx_rdy_n_r, hd_r;
         logic       fifo_en, blk, hd, wr;
         logic       rx_has, tx_empty, all_empty, tx_int, rx_int;
         logic [CW-1:0] rtrg, ttrg;

         assign wr       = acc_start && !acc_rd && sel[g];
         assign fifo_en  = fcr_r[FCR_FIFO_EN_BIT];
         assign blk      = fifo_en && fcr_r[FCR_BLOCK_BIT];           // RULE_07
         assign hd       = feature_control_reg_r[FEATURE_CONTROL_REG_HALF_DUP_BIT] || !half_duplex_enable_n; // RULE_20
         assign rx_has   = rx_count[g] != CNT_ZERO;
         assign tx_empty = tx_count[g] == CNT_ZERO;
         assign all_empty = tx_empty && tx_shift_empty[g];
         assign rtrg     = rtrg_r[CW-1:0];
         assign ttrg     = ttrg_r[CW-1:0];

         // register writes; with both separate selects low one write hits both channels at once
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin                                            // RULE_01
               dll_r  <= RST_DIV_LOW;
               dlm_r  <= RST_DIV_HIGH;
               dld_r  <= RST_DIV_FRAC;
               fcr_r  <= RST_FIFO_CTL;
               feature_control_reg_r <= RST_FEAT_CTL;                                // RULE_20
               rtrg_r <= RST_RX_TRIG;
               ttrg_r <= RST_TX_TRIG;
            end else if (wr) begin
               case (reg_addr)
                  OFS_DIV_LOW:  dll_r  <= write_data;
                  OFS_DIV_HIGH: dlm_r  <= write_data;
                  OFS_FIFO_CTL: fcr_r  <= write_data;
                  OFS_DIV_FRAC: dld_r  <= {4'h0, write_data[DIV_FRAC_BITS-1:0]};
                  OFS_FEAT_CTL: feature_control_reg_r <= write_data;
                  OFS_RX_TRIG:  rtrg_r <= write_data;
                  OFS_TX_TRIG:  ttrg_r <= write_data;
                  default:      ;
               endcase
            end
         end

         // receive ready
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               rx_rdy_n_r <= 1'b1;                                    // RULE_01
            end else if (!blk) begin
               rx_rdy_n_r <= !rx_has;                                 // RULE_08 RULE_09
            end else if (rx_count[g] >= rtrg || rx_timeout[g]) begin
               rx_rdy_n_r <= 1'b0;                                    // RULE_10
            end else if (!rx_has) begin
               rx_rdy_n_r <= 1'b1;                                    // RULE_10
            end
         end

         // transmit ready; with no fifo it mirrors the holding register
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tx_rdy_n_r <= 1'b0;
            end else if (blk) begin
               tx_rdy_n_r <= tx_count[g] >= CNT_FULL;                 // RULE_12
            end else begin
               tx_rdy_n_r <= !tx_empty;                               // RULE_11
            end
         end

         always_comb begin
            if (!fifo_en) begin
               tx_int = hd ? all_empty : tx_empty;                    // RULE_13 RULE_14
               rx_int = rx_has;                                       // RULE_16
            end else begin
               tx_int = hd ? ((!tx_empty && tx_count[g] < ttrg) || all_empty)
                           : (tx_count[g] < ttrg);                    // RULE_15 RULE_14
               rx_int = rx_count[g] > rtrg;                           // RULE_17
            end
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               hd_r <= 1'b0;
            end else begin
               hd_r <= hd;
            end
         end

         assign irq_w[g]  = tx_int || rx_int;
         assign dll_w[g]  = dll_r;
         assign dlm_w[g]  = dlm_r;
         assign dld_w[g]  = dld_r;
         assign fcr_w[g]  = fcr_r;
         assign feature_control_reg_w[g] = feature_control_reg_r;
         assign rtrg_w[g] = rtrg_r;
         assign ttrg_w[g] = ttrg_r;
         assign rx_ready_n[g]         = rx_rdy_n_r;
         assign tx_ready_n[g]         = tx_rdy_n_r;
         assign half_duplex_active[g] = hd_r;

         // line status: room and completely empty
         always_comb begin
            lsr_w[g] = 8'h00;
            lsr_w[g][LSR_DATA_RDY_BIT] = rx_has;
            lsr_w[g][LSR_TX_ROOM_BIT]  = fifo_en ? (tx_count[g] < CNT_FULL)
                                                 : tx_empty;          // RULE_19
            lsr_w[g][LSR_TX_EMPTY_BIT] = all_empty;                   // RULE_19
         end
      end
   endgenerate

   // read mux is pure selection, so id reads change no stored divisor
   logic       rch;
   logic [7:0] rmux;
   always_comb begin                                                  // RULE_21
      rch  = !sel[0];                                                 // RULE_04
      case (reg_addr)
         OFS_DIV_LOW:   rmux = (dll_w[rch] == DIV_ZERO && dlm_w[rch] == DIV_ZERO)
                               ? REVISION : dll_w[rch];               // RULE_02
         OFS_DIV_HIGH:  rmux = (dll_w[rch] == DIV_ZERO && dlm_w[rch] == DIV_ZERO)
                               ? DEVICE_ID : dlm_w[rch];              // RULE_02
         OFS_FIFO_CTL:  rmux = fcr_w[rch];
         OFS_DIV_FRAC:  rmux = dld_w[rch];
         OFS_FEAT_CTL:  rmux = feature_control_reg_w[rch];
         OFS_LINE_STAT: rmux = lsr_w[rch];
         OFS_RX_TRIG:   rmux = rtrg_w[rch];
         OFS_TX_TRIG:   rmux = ttrg_w[rch];
         default:       rmux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         read_data    <= 8'h00;
         read_data_oe <= 1'b0;
      end else begin
         read_data    <= (acc_on && acc_rd) ? rmux : 8'h00;
         read_data_oe <= acc_on && acc_rd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_out_chan_a <= 1'b0;
         irq_out_chan_b <= 1'b0;
      end else begin
         irq_out_chan_a <= irq_w[0];
         irq_out_chan_b <= irq_w[1];
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sep_select: assert property (bus_style && !select_chan_a_n && select_chan_b_n
                                  |-> sel == 2'b01)                   // RULE_03
      else $error("separate select a did not pick channel a");
   a_single_select: assert property (!bus_style && !select_chan_a_n
                                     |-> sel == {channel_address_bit, !channel_address_bit})
      else $error("single select decode wrong");                      // RULE_05
   a_style_none: assert property (!bus_style && select_chan_a_n |-> sel == 2'b00)
      else $error("deselected single style still selects");           // RULE_06
   a_id_read: assert property (acc_on && acc_rd && reg_addr == OFS_DIV_HIGH
                               && dll_w[rch] == DIV_ZERO && dlm_w[rch] == DIV_ZERO
                               |=> read_data == DEVICE_ID)            // RULE_02
      else $error("id not returned with zero divisor");
   a_id_keeps_div: assert property (acc_on && acc_rd |=> $stable(dll_w) && $stable(dlm_w)
                                    && $stable(dld_w))                // RULE_21
      else $error("read changed a divisor");
   a_rx_ready_nofifo: assert property (!g_ch[0].fifo_en
                                       |=> rx_ready_n[0] == !$past(g_ch[0].rx_has))
      else $error("receive ready wrong with fifo off");               // RULE_08
   a_rx_block_fall: assert property (g_ch[0].blk && rx_timeout[0] |=> !rx_ready_n[0])
      else $error("block receive ready missed time-out");             // RULE_10
   a_tx_block_full: assert property (g_ch[0].blk && tx_count[0] == CNT_FULL
                                     |=> tx_ready_n[0])                // RULE_12
      else $error("transmit ready low with full fifo");
   a_tx_ready_char: assert property (g_ch[0].fifo_en && !g_ch[0].blk
                                     |=> tx_ready_n[0] == ($past(tx_count[0]) != CNT_ZERO))
      else $error("transmit ready wrong in single-character mode");   // RULE_11
   a_hd_waits: assert property (!g_ch[0].fifo_en && g_ch[0].hd && !tx_shift_empty[0]
                                && rx_count[0] == CNT_ZERO |=> !irq_out_chan_a)
      else $error("half duplex interrupt before shifter empty");      // RULE_14
   a_lsr_empty: assert property (lsr_w[0][LSR_TX_EMPTY_BIT]
                                 |-> tx_count[0] == CNT_ZERO && tx_shift_empty[0])
      else $error("line status empty bit wrong");                     // RULE_19

   // remaining pin conditions, second channel included
   a_rx_ready_fifo: assert property (g_ch[0].fifo_en && !g_ch[0].blk // RULE_09
                                     |=> rx_ready_n[0] == !$past(g_ch[0].rx_has))
      else $error("receive ready wrong with fifo on");
   a_rx_block_rise: assert property (g_ch[0].blk && rx_count[0] == CNT_ZERO // RULE_10
                                     && !rx_timeout[0] |=> rx_ready_n[0])
      else $error("block receive ready stayed low with fifo empty");
   a_tx_block_room: assert property (g_ch[0].blk && tx_count[0] < CNT_FULL // RULE_12
                                     |=> !tx_ready_n[0])
      else $error("block transmit ready high with room left");
   a_tx_irq_thr: assert property (!g_ch[0].fifo_en && !g_ch[0].hd // RULE_13
                                  && tx_count[0] == CNT_ZERO |=> irq_out_chan_a)
      else $error("no interrupt with holding register empty");
   a_tx_irq_trig: assert property (g_ch[0].fifo_en && !g_ch[0].hd // RULE_15
                                   && tx_count[0] < g_ch[0].ttrg |=> irq_out_chan_a)
      else $error("no interrupt below transmit trigger");
   a_rx_irq_byte: assert property (!g_ch[0].fifo_en && g_ch[0].rx_has // RULE_16
                                   |=> irq_out_chan_a)
      else $error("no interrupt with received byte held");
   a_rx_irq_trig: assert property (g_ch[0].fifo_en && rx_count[0] > g_ch[0].rtrg // RULE_17
                                   |=> irq_out_chan_a)
      else $error("no interrupt above receive trigger");
   a_irq_quiet_b: assert property (!g_ch[1].fifo_en && !g_ch[1].rx_has // RULE_16
                                   && !g_ch[1].tx_empty |=> !irq_out_chan_b)
      else $error("channel b interrupt with nothing pending");
   a_rx_ready_b: assert property (!g_ch[1].fifo_en // RULE_08
                                  |=> rx_ready_n[1] == !$past(g_ch[1].rx_has))
      else $error("channel b receive ready wrong with fifo off");
   a_tx_block_b: assert property (g_ch[1].blk && tx_count[1] == CNT_FULL // RULE_12
                                  |=> tx_ready_n[1])
      else $error("channel b transmit ready low with full fifo");
   a_hd_follows: assert property (g_ch[0].hd |=> half_duplex_active[0]) // RULE_20
      else $error("half duplex not shown active");
   a_hd_off_pin: assert property (half_duplex_enable_n // RULE_20
                                  && !g_ch[0].feature_control_reg_r[FEATURE_CONTROL_REG_HALF_DUP_BIT] |=> !half_duplex_active[0])
      else $error("half duplex active with bit and pin off");
   a_read_quiet: assert property (!(acc_on && acc_rd) // RULE_06
                                  |=> !read_data_oe && read_data == 8'h00)
      else $error("read data driven with no read");
   a_both_select: assert property (bus_style && !select_chan_a_n && !select_chan_b_n // RULE_03
                                   |-> sel == 2'b11)
      else $error("both selects did not pick both channels");

   c_both_write: cover property (acc_start && !acc_rd && sel == 2'b11);
   c_block_rx:   cover property (g_ch[0].blk && rx_ready_n[0] ##1 !rx_ready_n[0]);
   c_id_read:    cover property (read_data_oe && read_data == DEVICE_ID);
   c_hd_drain:   cover property (g_ch[0].hd && !tx_shift_empty[0] ##1 tx_shift_empty[0]);
   c_single_b:   cover property (!bus_style && acc_start && sel == 2'b10);
endmodule : duhssp_top

//--- sim/duhssp_host_model.sv
/*
 host processor bus model: drives either bus style, changing pins at the
 falling clock edge. assumes the block takes accesses on the rising edge.
*/
`timescale 1ns/1ps
module duhssp_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] read_data,
   input  wire logic       read_data_oe,
   output logic            bus_style,
   output logic            select_chan_a_n,
   output logic            select_chan_b_n,
   output logic            channel_address_bit,
   output logic            read_strobe_n,
   output logic            write_strobe_n,
   output logic            read_not_write,
   output logic      [2:0] reg_addr,
   output logic      [7:0] write_data
);
   task automatic idle;
      select_chan_a_n = 1'h1;
      select_chan_b_n = 1'h1;
      read_strobe_n   = 1'h1;
      write_strobe_n  = 1'h1;
      read_not_write  = 1'h1;
      // released data shows the inverse, so a stale copy never passes
      write_data      = ~write_data;
   endtask : idle
   initial begin
      bus_style           = 1'h1;
      channel_address_bit = 1'h0;
      reg_addr            = 3'h0;
      write_data          = 8'h00;
      idle();
   end
   task automatic set_style(input logic s);
      @(negedge clk);
      bus_style = s;
   endtask : set_style
   task automatic go(input logic [1:0] ch, input logic r);
      if (bus_style) begin
         select_chan_a_n = ~ch[0];
         select_chan_b_n = ~ch[1];
         read_strobe_n   = ~r;
         write_strobe_n  = r;
      end else begin
         select_chan_a_n     = 1'h0;
         channel_address_bit = ch[1];
         read_not_write      = r;
      end
   endtask : go
   // held one edge, then two idle cycles before the next access
   task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr   = a;
      write_data = d;
      go(ch, 1'h0);
      @(negedge clk);
      idle();
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic c, input logic [2:0] a, output logic [8:0] q);
      @(negedge clk);
      reg_addr = a;
      go({c, ~c}, 1'h1);
      @(negedge clk);
      q = {read_data_oe, read_data};
      idle();
      @(negedge clk);
   endtask : rd
endmodule : duhssp_host_model

//--- sim/duhssp_top_tb.sv
/*
 self-checking bench of the host select and status block.
 assumes duhssp_host_model drives the host bus; channel core inputs from here.
*/
`timescale 1ns/1ps
module duhssp_top_tb;
   import duhssp_pkg::*;
   localparam logic [7:0] ID_CODE  = 8'h5c; // arbitrary value
   localparam logic [7:0] REV_CODE = 8'h03; // arbitrary value
   logic            clk, rst, hd_n;
   logic [1:0][6:0] rx_count, tx_count;
   logic [1:0]      rx_timeout, tx_shift_empty;
   wire logic       bus_style, select_chan_a_n, select_chan_b_n, channel_address_bit;
   wire logic       read_strobe_n, write_strobe_n, read_not_write, read_data_oe;
   wire logic [2:0] reg_addr;
   wire logic [7:0] write_data, read_data;
   wire logic [1:0] rx_ready_n, tx_ready_n, half_duplex_active, irq;
   wire logic       irq_out_chan_a, irq_out_chan_b;
   logic [8:0]      q;
   int              errors, checked;
   assign irq = {irq_out_chan_b, irq_out_chan_a};

   duhssp_top #(.FIFO_DEPTH(64), .DEVICE_ID(ID_CODE), .REVISION(REV_CODE)) i_duhssp_top (
      .clk, .rst, .bus_style, .select_chan_a_n, .select_chan_b_n, .channel_address_bit,
      .read_strobe_n, .write_strobe_n, .read_not_write, .reg_addr, .write_data,
      .half_duplex_enable_n(hd_n), .rx_count, .tx_count, .rx_timeout, .tx_shift_empty,
      .read_data, .read_data_oe, .rx_ready_n, .tx_ready_n, .irq_out_chan_a,
      .irq_out_chan_b, .half_duplex_active);
   duhssp_host_model i_duhssp_host_model (
      .clk, .read_data, .read_data_oe, .bus_style, .select_chan_a_n, .select_chan_b_n,
      .channel_address_bit, .read_strobe_n, .write_strobe_n, .read_not_write,
      .reg_addr, .write_data);

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rdc(input logic c, input logic [2:0] a, input logic [7:0] e);
      i_duhssp_host_model.rd(c, a, q);
      chk("read", q, {1'h1, e});
   endtask : rdc
   // r t o s: rx level, tx level, time-out, shifter empty; e = {rx rdy, tx rdy, irq}
   task automatic st(input int c, input logic [6:0] r, t, input logic o, s, input logic [2:0] e);
      @(negedge clk);
      rx_count[c]       = r;
      tx_count[c]       = t;
      rx_timeout[c]     = o;
      tx_shift_empty[c] = s;
      @(negedge clk);
      chk("pins", {6'h0, rx_ready_n[c], tx_ready_n[c], irq[c]}, {6'h0, e});
   endtask : st
   task automatic defaults;
      logic [7:0] rv [8];
      rv = '{RST_DIV_LOW, RST_DIV_HIGH, RST_FIFO_CTL, RST_DIV_FRAC, RST_FEAT_CTL,
             8'h00, RST_RX_TRIG, RST_TX_TRIG};
      for (int c = 0; c < 2; c++) begin
         for (int a = 0; a < 8; a++) begin
            if (a != 5) rdc(c[0], a[2:0], rv[a]);
         end
      end
   endtask : defaults
   task automatic do_reset;
      rx_count = '0;
      tx_count = '0;
      rx_timeout = 2'h0;
      tx_shift_empty = 2'h3;
      rst = 1'h1;
      repeat (12) @(negedge clk);
      // the pins must be at rest while reset holds, whatever the inputs say
      chk("reset pins", {1'h0, rx_ready_n, tx_ready_n, irq, half_duplex_active}, 9'h0c0);
      rst = 1'h0;
   endtask : do_reset
   task automatic t_ident;
      i_duhssp_host_model.wr(2'h3, OFS_DIV_LOW, 8'h00);
      i_duhssp_host_model.wr(2'h3, OFS_DIV_HIGH, 8'h00);
      i_duhssp_host_model.wr(2'h2, OFS_DIV_FRAC, 8'h5a);
      rdc(1'h1, OFS_DIV_HIGH, ID_CODE);
      rdc(1'h1, OFS_DIV_LOW, REV_CODE);
      rdc(1'h1, OFS_DIV_FRAC, 8'h0a);
      rdc(1'h0, OFS_DIV_HIGH, ID_CODE);
      i_duhssp_host_model.wr(2'h2, OFS_DIV_LOW, 8'h12);
      rdc(1'h1, OFS_DIV_LOW, 8'h12);
      $display("test ident done");
   endtask : t_ident
   task automatic t_pins;
      st(0, 7'd0, 7'd1, 1'h0, 1'h1, 3'b110);
      st(0, 7'd1, 7'd1, 1'h0, 1'h1, 3'b011);
      st(0, 7'd0, 7'd0, 1'h0, 1'h1, 3'b101);
      st(1, 7'd1, 7'd1, 1'h0, 1'h1, 3'b011);
      st(1, 7'd0, 7'd1, 1'h0, 1'h1, 3'b110);
      i_duhssp_host_model.wr(2'h1, OFS_FIFO_CTL, 8'h01);
      st(0, 7'd0, 7'd0, 1'h0, 1'h1, 3'b101);
      st(0, 7'd1, 7'd9, 1'h0, 1'h1, 3'b010);
      st(0, 7'd9, 7'd9, 1'h0, 1'h1, 3'b011);
      st(0, 7'd8, 7'd9, 1'h0, 1'h1, 3'b010);
      st(0, 7'd0, 7'd7, 1'h0, 1'h1, 3'b111);
      i_duhssp_host_model.wr(2'h1, OFS_FIFO_CTL, 8'h09);
      st(0, 7'd3, 7'd9, 1'h0, 1'h1, 3'b100);
      st(0, 7'd8, 7'd9, 1'h0, 1'h1, 3'b000);
      st(0, 7'd3, 7'd9, 1'h0, 1'h1, 3'b000);
      st(0, 7'd0, 7'd9, 1'h0, 1'h1, 3'b100);
      st(0, 7'd2, 7'd9, 1'h1, 1'h1, 3'b000);
      st(0, 7'd0, 7'd64, 1'h0, 1'h1, 3'b110);
      st(0, 7'd0, 7'd63, 1'h0, 1'h1, 3'b100);
      $display("test pins done");
   endtask : t_pins
   task automatic t_half;
      do_reset();
      chk("hd", {7'h0, half_duplex_active}, 9'h000);
      hd_n = 1'h0;
      st(0, 7'd0, 7'd0, 1'h0, 1'h0, 3'b100);
      chk("hd", {7'h0, half_duplex_active}, 9'h003);
      st(0, 7'd0, 7'd0, 1'h0, 1'h1, 3'b101);
      hd_n = 1'h1;
      i_duhssp_host_model.wr(2'h1, OFS_FEAT_CTL, 8'h08);
      chk("hd", {7'h0, half_duplex_active}, 9'h001);
      i_duhssp_host_model.wr(2'h1, OFS_FIFO_CTL, 8'h01);
      st(0, 7'd0, 7'd0, 1'h0, 1'h0, 3'b100);
      st(0, 7'd0, 7'd3, 1'h0, 1'h0, 3'b111);
      i_duhssp_host_model.rd(1'h0, OFS_LINE_STAT, q);
      chk("lsr", {7'h0, q[6:5]}, 9'h001);
      st(0, 7'd0, 7'd64, 1'h0, 1'h1, 3'b110);
      i_duhssp_host_model.rd(1'h0, OFS_LINE_STAT, q);
      chk("lsr", {7'h0, q[6:5]}, 9'h000);
      st(0, 7'd0, 7'd0, 1'h0, 1'h1, 3'b101);
      i_duhssp_host_model.rd(1'h0, OFS_LINE_STAT, q);
      chk("lsr", {7'h0, q[6:5]}, 9'h003);
      $display("test half duplex done");
   endtask : t_half
   task automatic t_select;
      i_duhssp_host_model.wr(2'h1, OFS_RX_TRIG, 8'h11);
      i_duhssp_host_model.wr(2'h2, OFS_RX_TRIG, 8'h22);
      i_duhssp_host_model.wr(2'h0, OFS_RX_TRIG, 8'h33);
      rdc(1'h0, OFS_RX_TRIG, 8'h11);
      rdc(1'h1, OFS_RX_TRIG, 8'h22);
      i_duhssp_host_model.set_style(1'h0);
      i_duhssp_host_model.wr(2'h1, OFS_TX_TRIG, 8'h44);
      i_duhssp_host_model.wr(2'h2, OFS_TX_TRIG, 8'h55);
      rdc(1'h1, OFS_TX_TRIG, 8'h55);
      i_duhssp_host_model.set_style(1'h1);
      rdc(1'h0, OFS_TX_TRIG, 8'h44);
      $display("test select done");
   endtask : t_select
   task automatic print_verdict;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("BAD run time limit expected end seen none");
      print_verdict();
   end
   initial begin
      hd_n = 1'h1;
      do_reset();
      defaults();
      $display("test reset done");
      t_ident();
      t_pins();
      t_half();
      t_select();
      rx_count = {7'd1, 7'd1};
      do_reset();
      defaults();
      $display("test second reset done");
      print_verdict();
   end
endmodule : duhssp_top_tb
